/* File: tb/csi_far_model.sv */
// far-side device: clock source in external mode, data partner both ways
// assumes sck is the resolved clock wire
`timescale 1ns/1ps
module csi_far_model (
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic sdi,
  output logic ext_sck
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  initial begin
    {ext_sck, sdi} = 2'h3;
    {tx_byte, rx_byte} = 16'h0000;
  end
  // inverse fill so a stale line never repeats the last byte
  always @(negedge sck) begin
    sdi = tx_byte[7];
    tx_byte = {tx_byte[6:0], ~tx_byte[7]};
  end
  always @(posedge sck) begin
    if (sdo_oe_n === 1'b0)
      rx_byte = {rx_byte[6:0], sdo};
  end
  // clock stands high between frames
  task automatic frame(input int n);
    repeat (n) begin
      #160 ext_sck = 1'b0;
      #160 ext_sck = 1'b1;
    end
  endtask
endmodule

/* File: tb/csi_port_checker.sv */
// assertions on the serial port top-level pins
// assumes one mclk domain with synchronous active-high sys_rst
`timescale 1ns/1ps
module csi_port_checker
  import csi_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mode_wr,
  input wire logic shift_wr,
  input wire logic [7:0] serial_mode_register,
  input wire logic [7:0] shift_register,
  input wire logic busy,
  input wire logic transfer_complete_irq,
  input wire logic serial_clock_pin_out,
  input wire logic serial_data_out_pin,
  input wire logic serial_data_out_pin_oe_n
);
  logic [3:0] rises_reg;
  logic [3:0] rises_next;
  logic sck_prev_reg, busy_prev_reg, armed_reg;
  wire int_clk = |serial_mode_register[CLK_SRC_HI_POS:CLK_SRC_LO_POS];
  wire tx_on = serial_mode_register[TX_EN_POS];
  // pin rests high outside frames, so idle time adds no rises
  assign rises_next = (busy && !busy_prev_reg) ? 4'h0 :
    rises_reg + {3'h0, serial_clock_pin_out && !sck_prev_reg};
  always_ff @(posedge mclk) begin
    rises_reg <= sys_rst ? 4'h0 : rises_next;
    sck_prev_reg <= serial_clock_pin_out;
    busy_prev_reg <= busy;
    // shift register is undefined until first written
    armed_reg <= !sys_rst && (armed_reg || shift_wr);
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence int_start;
    $rose(busy) && int_clk;
  endsequence
  sequence ext_quiet;
    !busy && !$past(busy) && !$past(busy, 2) && !int_clk && !$past(shift_wr)
      && !$past(mode_wr) && !$past(mode_wr, 2);
  endsequence
  a_irq_one_pulse: assert property (
    transfer_complete_irq |=> !transfer_complete_irq) else $error("irq longer than one cycle");
  a_irq_after_eight: assert property (transfer_complete_irq && int_clk |->
    rises_reg == 4'h8 || rises_next == 4'h8) else $error("irq not after eighth rise");
  a_irq_needs_busy: assert property ($rose(transfer_complete_irq) |->
    $past(busy) || $past(busy, 2)) else $error("irq without transfer");
  a_clk_rests_high: assert property (
    !busy && !$past(busy) |-> serial_clock_pin_out) else $error("clock low while idle");
  a_first_fall_soon: assert property (
    int_start |-> ##[1:8] $fell(serial_clock_pin_out)) else $error("first fall late");
  a_data_off_hiz: assert property (
    !tx_on ##1 !tx_on |-> serial_data_out_pin_oe_n) else $error("data out driven while disabled");
  a_ext_data_still: assert property (
    ext_quiet |-> $stable(serial_data_out_pin)) else $error("data out moved while idle");
  a_ext_no_shift: assert property (
    ext_quiet and armed_reg |-> $stable(shift_register)) else $error("shift while idle");
endmodule
bind csi_port csi_port_checker chk (.*);

/* File: tb/three_wire_clocked_serial_port_tb_top.sv */
// bench for the serial port: internal frames, abort, external reception
// assumes csi_far_model on the pins and the bound checker
`timescale 1ns/1ps
module three_wire_clocked_serial_port_tb_top;
  import csi_pkg::*;
  logic mclk, sys_rst, mode_wr, shift_wr, shift_rd, busy, transfer_complete_irq;
  logic serial_clock_pin_out, serial_clock_pin_oe_n, serial_data_in_pin, ext_sck;
  logic serial_data_out_pin, serial_data_out_pin_oe_n;
  logic [7:0] mode_wdata, shift_wdata, serial_mode_register, shift_register;
  wire serial_clock_pin_in = serial_clock_pin_oe_n ? ext_sck : serial_clock_pin_out;
  int fails, n_checks, irqs;
  csi_port dut (.*);
  csi_far_model far (.sck(serial_clock_pin_in), .sdo(serial_data_out_pin),
    .sdo_oe_n(serial_data_out_pin_oe_n), .sdi(serial_data_in_pin), .ext_sck(ext_sck));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (transfer_complete_irq === 1'b1) irqs++;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge mclk);
    #1 {mode_wr, shift_wr, shift_rd} = {k == 0, k == 1, k == 2};
    {mode_wdata, shift_wdata} = {v, v};
    @(posedge mclk);
    #1 {mode_wr, shift_wr, shift_rd} = 3'h0;
  endtask
  // bounded wait, then room for the sync delay and the irq pulse
  task automatic settle(input int n);
    int i;
    repeat (n) @(posedge mclk);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic xfer(input logic [7:0] m);
    int n0;
    n0 = irqs;
    {far.tx_byte, far.rx_byte} = 16'h1D00;
    strobe(0, m & (m[RX_EN_POS] ? 8'h3F : 8'hFF));
    strobe(1, 8'hC1);
    if (m[RX_EN_POS]) strobe(0, m);
    settle(3);
    check(far.rx_byte, m[0] ? 8'h83 : 8'hC1);
    check(shift_register, m[0] ? 8'hB8 : 8'h1D);
    check(8'(irqs - n0), 8'h01);
    check({7'h0, serial_clock_pin_out}, 8'h01);
    check({6'h0, serial_clock_pin_oe_n, serial_data_out_pin_oe_n}, 8'h00);
    $display("frame done, mode %h", m);
  endtask
  task automatic abort_tx();
    int n0;
    n0 = irqs;
    strobe(0, 8'h82);
    strobe(1, 8'hC1);
    repeat (20) @(posedge mclk);
    strobe(0, 8'h02);
    settle(1);
    check(8'(irqs - n0), 8'h00);
    check({5'h0, busy, serial_data_out_pin_oe_n, serial_clock_pin_out}, 8'h03);
    $display("abort done");
  endtask
  task automatic ext_rx();
    logic [7:0] held;
    int n0;
    strobe(0, 8'h00);
    {held, n0} = {shift_register, irqs};
    #7 far.frame(3);
    settle(4);
    check(shift_register, held);
    check({6'h0, serial_clock_pin_oe_n, serial_data_out_pin_oe_n}, 8'h03);
    strobe(0, 8'h40);
    far.tx_byte = 8'h1D;
    #7 far.frame(8);
    settle(4);
    check(shift_register, 8'h1D);
    check(8'(irqs - n0), 8'h01);
    $display("external frame done");
  endtask
  // cut an external reception after three clocks, then a full frame must follow
  task automatic ext_abort();
    int n0;
    n0 = irqs;
    strobe(0, 8'h00);
    strobe(0, 8'h40);
    #7 far.frame(3);
    strobe(0, 8'h00);
    settle(1);
    check({7'h0, busy}, 8'h00);
    check(8'(irqs - n0), 8'h00);
    strobe(0, 8'h40);
    far.tx_byte = 8'hA5;
    #7 far.frame(8);
    settle(4);
    check(shift_register, 8'hA5);
    check(8'(irqs - n0), 8'h01);
    $display("external abort done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {sys_rst, mode_wr, shift_wr, shift_rd, mode_wdata, shift_wdata} = 20'h80000;
    repeat (5) @(posedge mclk);
    #1 sys_rst = 1'b0;
    check(serial_mode_register, 8'h00);
    xfer(8'h82);
    xfer(8'h83);
    xfer(8'hC2);
    abort_tx();
    ext_rx();
    ext_abort();
    wrap_up();
  end
  initial begin
    #100000 fails++;
    wrap_up();
  end
endmodule

/* File: verilog/csi_clkgen.sv */
// internal serial clock generator, one-cycle edge pulses
// assumes run is a same-clock level
`timescale 1ns/1ps
module csi_clkgen
  import csi_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  csi_edge_if.src edges
);
  logic [7:0] div_reg;
  logic sck_reg;
  wire half_done = (div_reg == SCK_HALF_CYC - 8'h01);
  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      div_reg <= 8'h00;
      sck_reg <= 1'b1;
    end else if (half_done) begin
      div_reg <= 8'h00;
      sck_reg <= ~sck_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  // first fall one half period after run
  assign edges.fall = run & half_done & sck_reg;
  assign edges.rise = run & half_done & ~sck_reg;
  assign edges.level = sck_reg;
endmodule

/* File: verilog/csi_if.sv */
// interface carrying sampled serial-clock edges between modules
// assumes all signals on mclk
`timescale 1ns/1ps
interface csi_edge_if;
  logic rise;
  logic fall;
  logic level;
  modport src (output rise, output fall, output level);
  modport dst (input rise, input fall, input level);
endinterface

/* File: verilog/csi_pkg.sv */
// package of constants for the three-wire clocked serial port
// assumes a single 25 MHz system clock named mclk
// Summary of operation
// - eight bits per transfer, either order
// - bit order from bit-order select
// - drive after falling, sample on rising edge
// - irq on eighth rising clock edge
// - internal clock stops high after eighth rise
// - shift register write starts transmit; off means hi-z
// - transmit-only still shifts data-in on rises
// - first falling edge within one clock period
// - internal: tx disable aborts at next rise
// - external: early edges neither shift nor change output
// - external: tx disable aborts, ignores clock
// - reception starts on enable rise or read
// - internal: rx disable aborts at next rise
// - external: early clocks do not shift
// - external: rx disable aborts, no irq
// - full duplex starts on enable rise or write
// - disabling one direction stops only that one
// - internal: both off aborts at next rise
// - external: both off aborts, ignores clock
// - both off resets the bit counter
// - reset clears mode register to zero
// - count eight clocks then request irq
package csi_pkg;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int BIT_ORDER_POS = 0;
  localparam int CLK_SRC_LO_POS = 1;
  localparam int CLK_SRC_HI_POS = 2;
  localparam int RX_EN_POS = 6;
  localparam int TX_EN_POS = 7;
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam int SYS_CLK_MHZ = 25;
  // internal serial clock half period, in ns
  localparam int SCK_HALF_NS = 160;
  localparam int SCK_HALF_CYC_I = (SCK_HALF_NS * SYS_CLK_MHZ) / 1000;
  localparam logic [7:0] SCK_HALF_CYC = 8'(SCK_HALF_CYC_I < 1 ? 1 : SCK_HALF_CYC_I);
endpackage

/* File: verilog/csi_port.sv */
// three-wire clocked serial port, top level
// assumes software strobes are one-cycle pulses on mclk; pins asynchronous
`timescale 1ns/1ps
module csi_port
  import csi_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mode_wr,
  input wire logic [7:0] mode_wdata,
  output logic [7:0] serial_mode_register,
  input wire logic shift_wr,
  input wire logic [7:0] shift_wdata,
  input wire logic shift_rd,
  output logic [7:0] shift_register,
  output logic busy,
  output logic transfer_complete_irq,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin,
  output logic serial_data_out_pin_oe_n
);
  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  logic [7:0] mode_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_reg <= MODE_RESET;
    end else if (mode_wr) begin
      mode_reg <= mode_wdata;
    end
  end
  assign serial_mode_register = mode_reg;
  wire transmit_enable = mode_reg[TX_EN_POS];
  wire receive_enable = mode_reg[RX_EN_POS];
  wire bit_order_select = mode_reg[BIT_ORDER_POS];
  wire clock_source_sel_hi = mode_reg[CLK_SRC_HI_POS];
  wire clock_source_sel_lo = mode_reg[CLK_SRC_LO_POS];
  // any nonzero source code selects the internal clock
  wire internal_clk = clock_source_sel_hi | clock_source_sel_lo;
  wire any_en = transmit_enable | receive_enable;

  // ----------------------------------------------------------------
  // serial clock sources
  // ----------------------------------------------------------------
  logic busy_reg;
  csi_edge_if ext_e ();
  csi_edge_if int_e ();
  csi_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(serial_clock_pin_in),
    .edges(ext_e)
  );
  csi_clkgen u_clkgen (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(busy_reg & internal_clk),
    .edges(int_e)
  );
  wire sck_rise = internal_clk ? int_e.rise : ext_e.rise;
  wire sck_fall = internal_clk ? int_e.fall : ext_e.fall;

  // ----------------------------------------------------------------
  // start and abort conditions
  // ----------------------------------------------------------------
  logic rx_en_last_reg;
  logic tx_en_last_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_en_last_reg <= 1'b0;
      tx_en_last_reg <= 1'b0;
    end else begin
      rx_en_last_reg <= receive_enable;
      tx_en_last_reg <= transmit_enable;
    end
  end
  wire rx_rise = receive_enable & ~rx_en_last_reg;
  wire start_tx = transmit_enable & shift_wr;
  wire start_rx = receive_enable & (rx_rise | shift_rd);
  wire start = start_tx | start_rx;
  // abort pending: every enabled direction at start has been dropped
  logic tx_act_reg;
  logic rx_act_reg;
  wire tx_live = tx_act_reg & transmit_enable;
  wire rx_live = rx_act_reg & receive_enable;
  wire all_off = ~tx_live & ~rx_live;
  // internal waits for the next rise; external stops at once
  wire abort_now = busy_reg & all_off & (~internal_clk | sck_rise);

  // ----------------------------------------------------------------
  // bit counter and shifter
  // ----------------------------------------------------------------
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic so_reg;
  logic irq_reg;
  wire last_rise = busy_reg & sck_rise & (cnt_reg == FRAME_BITS - 4'h1);
  wire out_bit = bit_order_select ? shift_reg[0] : shift_reg[7];
  logic si_meta_reg;
  logic serial_data_in_s;
  wire [7:0] shifted = bit_order_select ? {serial_data_in_s, shift_reg[7:1]}
                                        : {shift_reg[6:0], serial_data_in_s};
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      si_meta_reg <= 1'b0;
      serial_data_in_s <= 1'b0;
    end else begin
      si_meta_reg <= serial_data_in_pin;
      serial_data_in_s <= si_meta_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      tx_act_reg <= 1'b0;
      rx_act_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= 1'b0;
      if (!any_en) begin
        busy_reg <= 1'b0;
        cnt_reg <= 4'h0;
        tx_act_reg <= 1'b0;
        rx_act_reg <= 1'b0;
        if (busy_reg && internal_clk && !sck_rise) begin
          busy_reg <= 1'b1; // held to the next rise
        end
      end else if (abort_now) begin
        busy_reg <= 1'b0; // no irq on abort
        cnt_reg <= 4'h0;
      end else if (last_rise) begin
        busy_reg <= 1'b0;
        cnt_reg <= 4'h0;
        irq_reg <= 1'b1;
      end else if (busy_reg && sck_rise) begin
        cnt_reg <= cnt_reg + 4'h1;
      end else if (!busy_reg && start) begin
        busy_reg <= 1'b1;
        cnt_reg <= 4'h0;
        tx_act_reg <= transmit_enable;
        rx_act_reg <= receive_enable;
      end
    end
  end

  // shifter: rises move data in even when only transmitting
  always_ff @(posedge mclk) begin
    if (!busy_reg && shift_wr) begin
      shift_reg <= shift_wdata;
    end else if (busy_reg && sck_rise && !abort_now) begin
      shift_reg <= shifted;
    end
  end

  // output latch updates only on falls inside a transfer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      so_reg <= 1'b1;
    end else if (!busy_reg && shift_wr) begin
      so_reg <= so_reg;
    end else if (busy_reg && sck_fall && tx_live) begin
      so_reg <= out_bit;
    end
  end

  // ----------------------------------------------------------------
  // pins and status
  // ----------------------------------------------------------------
  assign serial_data_out_pin = so_reg;
  assign serial_data_out_pin_oe_n = ~(transmit_enable & (tx_live | ~busy_reg));
  // idle internal clock rests high
  assign serial_clock_pin_out = internal_clk ? int_e.level : 1'b1;
  assign serial_clock_pin_oe_n = ~internal_clk;
  assign shift_register = shift_reg;
  assign busy = busy_reg;
  assign transfer_complete_irq = irq_reg;
endmodule

/* File: verilog/csi_sync.sv */
// two-flop synchroniser with edge detection
// assumes the input is asynchronous to mclk
`timescale 1ns/1ps
module csi_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic async_in,
  csi_edge_if.src edges
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  // edges only from the second stage onward
  assign edges.rise = sync_reg & ~last_reg;
  assign edges.fall = ~sync_reg & last_reg;
  assign edges.level = sync_reg;
endmodule
